// ==== design/ushdp_map.vh ====
`ifndef USHDP_MAP_VH
`define USHDP_MAP_VH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define USHDP_ALIAS_FIRST 32'h50020130
`define USHDP_ALIAS_LAST 32'h5002016C
`define USHDP_DATA3_ADDR 32'h5002013C
`define USHDP_CTRL_ADDR 32'h50020100
`define USHDP_LNS_ADDR 32'h50020104
`define USHDP_ISTAT_ADDR 32'h50020108
`define USHDP_IMASK_ADDR 32'h5002010C
`define USHDP_DIV_ADDR 32'h50020110
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define USHDP_CTRL_FIFO_EN 0
`define USHDP_CTRL_IR_MODE 1
`define USHDP_LNS_DATA_READY 0
`define USHDP_LNS_OVERRUN 1
`define USHDP_LNS_HOLD_EMPTY 5
`define USHDP_LNS_TX_IDLE 6
`define USHDP_INT_RX 0
`define USHDP_INT_OVERRUN 1
`define USHDP_INT_HOLD_EMPTY 2
// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define USHDP_CTRL_RST_FIFO 1'b0
`define USHDP_CTRL_RST_IR 1'b0
`define USHDP_MASK_RST 3'h0
`define USHDP_DIV_RST 16'h0010
`define USHDP_DATA_RST 8'h00
`endif

// ==== design/ushdp_fifo.v ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Synchronous FIFO; a push while full is dropped, contents kept
// ----------------------------------------------------------------
module ushdp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_flush,
    input wire i_push,
    input wire [WIDTH-1:0] i_data,
    input wire i_pop,
    output wire [WIDTH-1:0] o_head,
    output wire o_full,
    output wire o_empty
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage, no reset needed
    reg [AW-1:0] wr_ptr_q; // Next write slot
    reg [AW-1:0] rd_ptr_q; // Head slot
    reg [AW:0] count_q; // Entries held
    wire do_push; // Push that is accepted
    wire do_pop; // Pop that is accepted

    assign o_full = (count_q == DEPTH[AW:0]);
    assign o_empty = (count_q == {(AW+1){1'b0}});
    assign o_head = mem[rd_ptr_q];
    // Full push is lost so the queue is never disturbed
    assign do_push = i_push & ~o_full;
    assign do_pop = i_pop & ~o_empty;

    // Storage write
    always @(posedge i_clk_sys) begin
        if (do_push) begin
            mem[wr_ptr_q] <= i_data;
        end
    end

    // Pointers and count
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else if (i_flush) begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ?
                    {AW{1'b0}} : wr_ptr_q + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ?
                    {AW{1'b0}} : rd_ptr_q + 1'b1;
            end
            if (do_push & ~do_pop) begin
                count_q <= count_q + 1'b1;
            end else if (do_pop & ~do_push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule // ushdp_fifo

// ==== design/ushdp_uart_tx.v ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Serialiser: start bit, eight data bits LSB first, one stop bit
// ----------------------------------------------------------------
module ushdp_uart_tx (
    input wire i_clk_sys,
    input wire i_rst,
    input wire [15:0] i_divisor,
    input wire i_start,
    input wire [7:0] i_data,
    output wire o_busy,
    output wire o_line
);
    reg [9:0] shift_q; // Frame bits still to send
    reg [3:0] bits_q; // Bits left in frame
    reg [15:0] cnt_q; // Cycles left in current bit
    reg line_q; // Line level, idle high

    assign o_busy = (bits_q != 4'h0);
    assign o_line = line_q;

    // Bit timing; each bit lasts divisor+1 clocks
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            shift_q <= 10'h3FF;
            bits_q <= 4'h0;
            cnt_q <= 16'h0000;
            line_q <= 1'b1;
        end else if (!o_busy) begin
            line_q <= 1'b1;
            if (i_start) begin
                // Start bit goes out at once
                shift_q <= {1'b1, 1'b1, i_data};
                line_q <= 1'b0;
                bits_q <= 4'hA;
                cnt_q <= i_divisor;
            end
        end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 1'b1;
        end else begin
            bits_q <= bits_q - 1'b1;
            cnt_q <= i_divisor;
            line_q <= shift_q[0];
            shift_q <= {1'b1, shift_q[9:1]};
        end
    end
endmodule // ushdp_uart_tx

// ==== design/ushdp_top.v ====
`timescale 1ns/1ps
`include "ushdp_map.vh"
// Function
// [RULE1] Sixteen word aliases of shared data port
// [RULE2] Low byte reads serial or infrared character
// [RULE3] Read data valid only with data ready
// [RULE4] No FIFO: new character overwrites, flags overrun
// [RULE5] FIFO mode: read returns receive FIFO head
// [RULE6] Full receive FIFO drops arrival, flags overrun
// [RULE7] Written byte goes out serial or infrared
// [RULE8] Master writes only while holding empty set
// [RULE9] No FIFO: single write clears holding empty
// [RULE10] No FIFO: further writes overwrite holding data
// [RULE11] FIFO mode accepts writes up to depth
// [RULE12] Write to full transmit FIFO is discarded
// [RULE13] Upper bits read zero, writes ignored
module ushdp_top #(
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire i_clk_sys,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [31:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire i_sin,
    input wire i_sir_in,
    output wire o_sout,
    output wire o_sir_out_n,
    output wire o_irq
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    // Receive states
    localparam RX_IDLE = 2'b00, RX_START = 2'b01,
        RX_DATA = 2'b10, RX_STOP = 2'b11;
    reg [31:0] prdata_q; // Captured read word
    reg pready_q; // One wait state per access
    reg pslverr_q; // Error on unmapped address
    reg fifo_en_q; // FIFO enable control
    reg ir_mode_q; // Infrared pin select
    reg [2:0] mask_q; // Interrupt mask
    reg [15:0] div_q; // Bit period minus one
    reg [2:0] istat_q; // Sticky interrupt status
    reg overrun_q; // Line status overrun flag
    reg [7:0] rxbuf_q; // Single receive buffer
    reg rxbuf_valid_q; // Buffer holds unread char
    reg [7:0] hold_q; // Single transmit holding
    reg hold_full_q; // Holding has pending char
    reg hold_empty_prev_q; // For rising-edge event
    reg pop_ok_q; // Captured: read may consume
    reg [2:0] cap_istat_q; // Captured status to clear
    reg cap_ovr_q; // Captured overrun to clear
    reg sin_s1_q, sin_s2_q; // Serial pin synchroniser
    reg sir_s1_q, sir_s2_q; // Infrared pin synchroniser
    reg [1:0] rx_state_q; // Receive state
    reg [15:0] rx_cnt_q; // Cycles to next sample
    reg [2:0] rx_bit_q; // Data bit index
    reg [7:0] rx_shift_q; // Assembling char
    reg rx_valid_q; // One-cycle char arrival
    reg sout_q, sir_out_n_q; // Pins, both idle high
    reg irq_q; // Interrupt level
    reg fifo_en_prev_q; // Detects enable change
    reg [31:0] rd_word; // Read mux
    reg rd_err; // Unmapped decode
    wire acc, done; // Access phase, completion edge
    wire wr_done, rd_done; // Completion per direction
    wire alias_hit; // Any of the sixteen aliases
    wire rx_line; // Selected receive level
    wire data_ready, hold_empty; // Line status flags
    wire rxf_full, rxf_empty, txf_full, txf_empty; // FIFO flags
    wire [7:0] rxf_head, txf_head; // FIFO heads
    wire tx_busy, tx_line; // Serialiser state and level
    wire tx_start; // Engine takes next char
    wire data_wr, data_rd_pop; // Port write, consuming read
    wire rx_overrun; // Arrival lost or overwrite
    wire flush; // Mode change empties FIFOs
    wire [2:0] ev; // Interrupt events this cycle
    assign o_prdata = prdata_q;
    assign o_pready = pready_q;
    assign o_pslverr = pslverr_q;
    assign o_sout = sout_q;
    assign o_sir_out_n = sir_out_n_q;
    assign o_irq = irq_q;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign acc = i_psel & i_penable;
    assign done = acc & pready_q;
    assign wr_done = done & i_pwrite & ~pslverr_q;
    assign rd_done = done & ~i_pwrite & ~pslverr_q;
    // Whole alias range maps to one port for bursts
    assign alias_hit = (i_paddr >= `USHDP_ALIAS_FIRST) &&
        (i_paddr <= `USHDP_ALIAS_LAST) &&
        (i_paddr[1:0] == 2'b00); // [RULE1]
    assign data_wr = wr_done & alias_hit;
    assign data_rd_pop = rd_done & alias_hit & pop_ok_q;
    assign flush = fifo_en_q ^ fifo_en_prev_q;
    // Line status flags
    assign data_ready = fifo_en_q ? ~rxf_empty : rxbuf_valid_q;
    assign hold_empty = fifo_en_q ? txf_empty : ~hold_full_q;

    // Read mux; everything unnamed reads zero
    always @* begin
        rd_word = 32'h00000000;
        rd_err = 1'b0;
        if (alias_hit) begin
            // Upper 24 bits stay zero [RULE13]
            rd_word[7:0] = fifo_en_q ? rxf_head : rxbuf_q; // [RULE5]
        end else begin
            case (i_paddr)
                `USHDP_CTRL_ADDR: begin
                    rd_word[`USHDP_CTRL_FIFO_EN] = fifo_en_q;
                    rd_word[`USHDP_CTRL_IR_MODE] = ir_mode_q;
                end
                `USHDP_LNS_ADDR: begin
                    rd_word[`USHDP_LNS_DATA_READY] = data_ready; // [RULE3]
                    rd_word[`USHDP_LNS_OVERRUN] = overrun_q;
                    rd_word[`USHDP_LNS_HOLD_EMPTY] = hold_empty;
                    rd_word[`USHDP_LNS_TX_IDLE] = hold_empty & ~tx_busy;
                end
                `USHDP_ISTAT_ADDR: rd_word[2:0] = istat_q;
                `USHDP_IMASK_ADDR: rd_word[2:0] = mask_q;
                `USHDP_DIV_ADDR: rd_word[15:0] = div_q;
                default: rd_err = 1'b1;
            endcase
        end
    end

    // Answer one cycle into the access phase
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            pop_ok_q <= 1'b0;
            cap_istat_q <= 3'h0;
            cap_ovr_q <= 1'b0;
        end else if (acc & ~pready_q) begin
            // Capture now so data and side effects agree
            prdata_q <= i_pwrite ? 32'h00000000 : rd_word;
            pready_q <= 1'b1;
            pslverr_q <= rd_err;
            // Only a char actually returned gets consumed
            pop_ok_q <= data_ready; // [RULE3]
            cap_istat_q <= (i_paddr == `USHDP_ISTAT_ADDR) ?
                istat_q : 3'h0;
            cap_ovr_q <= (i_paddr == `USHDP_LNS_ADDR) & overrun_q;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            pop_ok_q <= 1'b0;
            cap_istat_q <= 3'h0;
            cap_ovr_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            fifo_en_q <= `USHDP_CTRL_RST_FIFO;
            ir_mode_q <= `USHDP_CTRL_RST_IR;
            mask_q <= `USHDP_MASK_RST;
            div_q <= `USHDP_DIV_RST;
            fifo_en_prev_q <= `USHDP_CTRL_RST_FIFO;
        end else begin
            fifo_en_prev_q <= fifo_en_q;
            if (wr_done && i_paddr == `USHDP_CTRL_ADDR) begin
                fifo_en_q <= i_pwdata[`USHDP_CTRL_FIFO_EN];
                ir_mode_q <= i_pwdata[`USHDP_CTRL_IR_MODE];
            end
            if (wr_done && i_paddr == `USHDP_IMASK_ADDR) begin
                mask_q <= i_pwdata[2:0];
            end
            if (wr_done && i_paddr == `USHDP_DIV_ADDR) begin
                // A written zero is loaded as one
                div_q <= (i_pwdata[15:0] == 16'h0000) ?
                    16'h0001 : i_pwdata[15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Receive path
    // ----------------------------------------------------------------
    // Pins are asynchronous: two flops before use
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sin_s1_q <= 1'b1;
            sin_s2_q <= 1'b1;
            sir_s1_q <= 1'b1;
            sir_s2_q <= 1'b1;
        end else begin
            sin_s1_q <= i_sin;
            sin_s2_q <= sin_s1_q;
            sir_s1_q <= i_sir_in;
            sir_s2_q <= sir_s1_q;
        end
    end

    assign rx_line = ir_mode_q ? sir_s2_q : sin_s2_q; // [RULE2]

    // Deserialiser; start checked at mid-bit
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rx_state_q <= RX_IDLE;
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 3'h0;
            rx_shift_q <= 8'h00;
            rx_valid_q <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            if (rx_state_q != RX_IDLE && rx_cnt_q != 16'h0000) begin
                // Count down to the next sample point
                rx_cnt_q <= rx_cnt_q - 1'b1;
            end else begin
                case (rx_state_q)
                    RX_IDLE: begin
                        if (!rx_line) begin
                            rx_cnt_q <= {1'b0, div_q[15:1]};
                            rx_state_q <= RX_START;
                        end
                    end
                    RX_START: begin
                        // High again at mid-bit: glitch, not a start
                        rx_cnt_q <= div_q;
                        rx_bit_q <= 3'h0;
                        rx_state_q <= rx_line ? RX_IDLE : RX_DATA;
                    end
                    RX_DATA: begin
                        rx_shift_q <= {rx_line, rx_shift_q[7:1]};
                        rx_cnt_q <= div_q;
                        rx_bit_q <= rx_bit_q + 1'b1;
                        if (rx_bit_q == 3'h7) begin
                            rx_state_q <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        // Bad stop bit: char is dropped
                        rx_valid_q <= rx_line;
                        rx_state_q <= RX_IDLE;
                    end
                    default: begin
                        rx_state_q <= RX_IDLE;
                    end
                endcase
            end
        end
    end
    // Overwrite in buffer mode, drop in FIFO mode
    assign rx_overrun = rx_valid_q & (fifo_en_q ? rxf_full :
        (rxbuf_valid_q & ~data_rd_pop)); // [RULE4] [RULE6]
    // Single receive buffer, FIFOs off
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rxbuf_q <= `USHDP_DATA_RST;
            rxbuf_valid_q <= 1'b0;
        end else if (fifo_en_q) begin
            rxbuf_valid_q <= 1'b0;
        end else if (rx_valid_q) begin
            // Newest char wins over an unread one
            rxbuf_q <= rx_shift_q; // [RULE4]
            rxbuf_valid_q <= 1'b1;
        end else if (data_rd_pop) begin
            rxbuf_valid_q <= 1'b0;
        end
    end
    ushdp_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_rx_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_flush(flush),
        .i_push(rx_valid_q & fifo_en_q), // [RULE6]
        .i_data(rx_shift_q),
        .i_pop(data_rd_pop & fifo_en_q), // [RULE5]
        .o_head(rxf_head),
        .o_full(rxf_full),
        .o_empty(rxf_empty)
    );

    // ----------------------------------------------------------------
    // Transmit path
    // ----------------------------------------------------------------
    // Writes drop when full; depth is a parameter
    ushdp_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_tx_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_flush(flush),
        .i_push(data_wr & fifo_en_q), // [RULE11] [RULE12]
        .i_data(i_pwdata[7:0]),
        .i_pop(tx_start & fifo_en_q),
        .o_head(txf_head),
        .o_full(txf_full),
        .o_empty(txf_empty)
    );

    assign tx_start = ~tx_busy & (fifo_en_q ? ~txf_empty : hold_full_q);
    // Single holding register, FIFOs off
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            hold_q <= `USHDP_DATA_RST;
            hold_full_q <= 1'b0;
        end else if (fifo_en_q) begin
            hold_full_q <= 1'b0;
        end else if (data_wr) begin
            // Later writes replace pending data [RULE10]
            hold_q <= i_pwdata[7:0]; // [RULE13]
            hold_full_q <= 1'b1; // [RULE9]
        end else if (tx_start) begin
            hold_full_q <= 1'b0;
        end
    end
    ushdp_uart_tx u_tx (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_divisor(div_q),
        .i_start(tx_start),
        .i_data(fifo_en_q ? txf_head : hold_q),
        .o_busy(tx_busy),
        .o_line(tx_line)
    );

    // ----------------------------------------------------------------
    // Status flags and interrupt
    // ----------------------------------------------------------------
    assign ev = {hold_empty & ~hold_empty_prev_q, rx_overrun, rx_valid_q};

    // Set wins over a read-clear in the same cycle
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            istat_q <= 3'h0;
            overrun_q <= 1'b0;
            hold_empty_prev_q <= 1'b1;
            irq_q <= 1'b0;
            sout_q <= 1'b1;
            sir_out_n_q <= 1'b1;
        end else begin
            // Unused pin idles high; infrared output is active low
            sout_q <= ir_mode_q ? 1'b1 : tx_line; // [RULE7]
            sir_out_n_q <= ir_mode_q ? tx_line : 1'b1; // [RULE7]
            hold_empty_prev_q <= hold_empty;
            istat_q <= (istat_q & ~(rd_done ? cap_istat_q : 3'h0)) | ev;
            overrun_q <= (overrun_q & ~(rd_done & cap_ovr_q)) |
                rx_overrun; // [RULE4] [RULE6]
            // Registered: lags status by one cycle
            irq_q <= |(istat_q & mask_q);
        end
    end
endmodule // ushdp_top

// ==== verif/ushdp_top_asserts.sv ====
`timescale 1ns/1ps
`include "ushdp_map.vh"
// ----------------------------------------------------------------
// Port checker for the data port
// ----------------------------------------------------------------
module ushdp_chk (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_sout,
    input wire logic o_sir_out_n
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    // Access cycle still waiting for its answer
    sequence s_acc;
        i_psel && i_penable && !o_pready;
    endsequence
    // Aligned access inside the sixteen-word alias window
    sequence s_alias;
        s_acc ##0 (i_paddr[1:0] == 2'h0 && i_paddr >= `USHDP_ALIAS_FIRST
            && i_paddr <= `USHDP_ALIAS_LAST);
    endsequence
    property p_answer; s_acc |=> o_pready; endproperty
    a_answer: assert property (p_answer) else $error("late answer");
    property p_once; o_pready |=> !o_pready; endproperty
    a_once: assert property (p_once) else $error("ready too long");
    property p_alias; s_alias |=> !o_pslverr; endproperty
    a_alias: assert property (p_alias) else $error("alias refused");
    property p_upper;
        s_alias ##0 !i_pwrite |=> o_prdata[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper bits");
    property p_unal; s_acc ##0 i_paddr[1:0] != 2'h0 |=> o_pslverr; endproperty
    a_unal: assert property (p_unal) else $error("no error");
    property p_errz; o_pslverr |-> o_pready && o_prdata == 32'h0; endproperty
    a_errz: assert property (p_errz) else $error("error data");
    // Only one of the two output pins may carry a frame
    property p_pins; !o_sir_out_n |-> o_sout; endproperty
    a_pins: assert property (p_pins) else $error("both pins");
    property p_cell; $fell(o_sout) |-> !o_sout [*8]; endproperty
    a_cell: assert property (p_cell) else $error("short bit");
endmodule // ushdp_chk
bind ushdp_top ushdp_chk ushdp_chk_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_sout(o_sout), .o_sir_out_n(o_sir_out_n));

// ==== verif/ushdp_peer.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Remote 8N1 transceiver
// ----------------------------------------------------------------
module ushdp_peer #(
    parameter int BP = 17
) (
    input wire logic i_clk_sys,
    input wire logic i_line,
    output logic o_sin,
    output logic o_sir_in
);
    logic [7:0] rx_q[$]; // Characters seen from the device
    initial o_sin = 1'b1; // Idle high
    initial o_sir_in = 1'b1;
    // One frame: start, LSB first, stop
    task automatic send(input logic [7:0] c, input logic ir);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clk_sys);
            if (ir) o_sir_in <= f[i];
            else o_sin <= f[i];
            repeat (BP - 1) @(posedge i_clk_sys);
        end
    endtask
    // Mid-cell sampling tolerates a clock of skew
    always begin : mon
        logic [7:0] c;
        @(negedge i_line);
        repeat (BP / 2) @(posedge i_clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BP) @(posedge i_clk_sys);
            c[i] = i_line;
        end
        repeat (BP) @(posedge i_clk_sys);
        rx_q.push_back(c);
    end
endmodule // ushdp_peer

// ==== verif/tb_uart_shadow_data_port.sv ====
`timescale 1ns/1ps
`include "ushdp_map.vh"
// ----------------------------------------------------------------
// Data port bench
// ----------------------------------------------------------------
module tb_uart_shadow_data_port;
    localparam int DEPTH = 4; // Small FIFO keeps frames few
    localparam logic [31:0] DAT = `USHDP_DATA3_ADDR;
    localparam logic [31:0] LNS = `USHDP_LNS_ADDR;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic ir = 1'b0; // When set, peer listens on the infrared pin
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic pready, pslverr, sout, sir_n, irq, sin, sir_in, err;
    logic [15:0] seed = 16'hC0A4;
    logic [7:0] b[6]; // Stimulus bytes
    int checks = 0;
    int fail_count = 0;
    always #20 clk = ~clk;
    ushdp_top #(.DEPTH(DEPTH), .AW(2)) ushdp_top_i (
        .i_clk_sys(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_sin(sin), .i_sir_in(sir_in),
        .o_sout(sout), .o_sir_out_n(sir_n), .o_irq(irq));
    ushdp_peer peer_i (.i_clk_sys(clk), .i_line(ir ? sir_n : sout),
        .o_sin(sin), .o_sir_in(sir_in));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Byte in the low lane, upper lanes zero
    function automatic logic [31:0] wd(input logic [7:0] c);
        return {24'h0, c};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic hang();
        fail_count++;
        summarize();
    endtask
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [31:0] a, d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Look mid-cycle: answer settled, not racing its own edge
        do begin
            @(negedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) hang();
        rdat = prdata;
        err = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic hold_wait();
        rdat = 32'h0; // Stale read data must not end the wait
        for (int n = 0; n < 200 && rdat[5] !== 1'b1; n++) apb(0, LNS, 0);
        if (rdat[5] !== 1'b1) hang();
    endtask
    task automatic wait_rx(input int k);
        for (int n = 0; n < 3000 && peer_i.rx_q.size() < k; n++)
            @(posedge clk);
        if (peer_i.rx_q.size() < k) hang();
    endtask
    initial begin
        foreach (b[i]) begin
            seed = lfsr(seed);
            b[i] = seed[7:0];
        end
        b[0] = 8'h00; // Corner bytes
        b[4] = 8'hFF;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(0, DAT, 0);
        chk(rdat, 32'h0);
        apb(0, 32'h50020131, 0);
        chk({31'h0, err}, 32'h1);
        for (int a = 0; a < 16; a++) begin
            apb(0, `USHDP_ALIAS_FIRST + 32'(4 * a), 0);
            chk({7'h0, err, rdat[31:8]}, 32'h0);
        end
        $display("test map done");
        apb(1, `USHDP_IMASK_ADDR, 32'h1);
        peer_i.send(b[0], 1'b0);
        peer_i.send(b[1], 1'b0);
        repeat (4) @(posedge clk);
        chk({31'h0, irq}, 32'h1); // Unmasked receive raises the line
        apb(0, LNS, 0);
        chk(rdat & 32'h3, 32'h3);
        apb(0, DAT, 0);
        chk(rdat, wd(b[1]));
        apb(0, LNS, 0);
        chk(rdat & 32'h1, 32'h0);
        apb(0, `USHDP_ISTAT_ADDR, 0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0); // Status read drops the line
        hold_wait();
        apb(1, DAT, {24'hFFFFFF, b[0]});
        apb(1, DAT, wd(b[1]));
        apb(0, LNS, 0);
        chk(rdat & 32'h20, 32'h0);
        apb(1, DAT, wd(b[2]));
        wait_rx(2);
        chk(wd(peer_i.rx_q.pop_front()), wd(b[0]));
        chk(wd(peer_i.rx_q.pop_front()), wd(b[2]));
        $display("test tx done");
        apb(1, `USHDP_IMASK_ADDR, 32'h0);
        apb(1, `USHDP_CTRL_ADDR, 32'h2);
        ir <= 1'b1;
        peer_i.send(b[3], 1'b1);
        repeat (4) @(posedge clk);
        chk({31'h0, irq}, 32'h0); // Masked event keeps the line low
        apb(0, `USHDP_ALIAS_LAST, 0);
        chk(rdat, wd(b[3]));
        hold_wait();
        apb(1, `USHDP_ALIAS_FIRST, wd(b[4]));
        wait_rx(1);
        chk(wd(peer_i.rx_q.pop_front()), wd(b[4]));
        $display("test ir done");
        apb(1, `USHDP_CTRL_ADDR, 32'h1);
        ir <= 1'b0;
        hold_wait();
        for (int i = 0; i < DEPTH + 2; i++) apb(1, DAT, wd(b[i]));
        wait_rx(DEPTH + 1);
        repeat (400) @(posedge clk);
        chk(32'(peer_i.rx_q.size()), DEPTH + 1);
        for (int i = 0; i <= DEPTH; i++)
            chk(wd(peer_i.rx_q.pop_front()), wd(b[i]));
        for (int i = 0; i <= DEPTH; i++) peer_i.send(b[i], 1'b0);
        repeat (4) @(posedge clk);
        apb(0, LNS, 0);
        chk(rdat & 32'h3, 32'h3);
        for (int i = 0; i < DEPTH; i++) begin
            apb(0, DAT, 0);
            chk(rdat, wd(b[i]));
        end
        apb(0, LNS, 0);
        chk(rdat & 32'h1, 32'h0);
        $display("test fifo done");
        summarize();
    end
endmodule // tb_uart_shadow_data_port
